// File: core/tcg_pkg.sv
package tcg_pkg;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int STRB_W = DATA_W / BYTE_W;
  localparam int WORD_LSB = 2;
  localparam int OWN_ADDR_W = 7;
  localparam int LOCK_W = 2;
  localparam int EV_W = 4;
  localparam int SETTLE_W = 3;

  //////////////////////////////////////////////////////////////////////////////

  localparam logic [ADDR_W-1:0] CFG_OFFSET = 20'h1D12C;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 20'h1D200;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET = 20'h1D204;

  localparam logic [DATA_W-1:0] CFG_RESET = 32'hD000_0030;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  localparam int BIT_RD_PERMIT = 31;
  localparam int BIT_WR_PERMIT = 30;
  localparam int BIT_ALERT_PERMIT = 29;
  localparam int BIT_RESPOND = 28;
  localparam int BIT_UNLOCK = 24;
  localparam int ADDR_MSB = 6;

  //////////////////////////////////////////////////////////////////////////////

  localparam logic [OWN_ADDR_W-1:0] ALERT_RESP_ADDR = 7'h0C;
  localparam logic [OWN_ADDR_W-1:0] GENERAL_CALL_ADDR = 7'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int EV_RD_DONE = 0;
  localparam int EV_WR_DONE = 1;
  localparam int EV_ALERT = 2;
  localparam int EV_DENIED = 3;

  localparam logic [SETTLE_W-1:0] STRAP_SETTLE = 3'h6;
  localparam logic [SETTLE_W-1:0] SETTLE_STEP = 3'h1;

  typedef enum logic {ST_SETTLE, ST_RUN} strap_state_t;

endpackage

// File: core/strap_sync.sv
`timescale 1ns/1ps

module strap_sync #(
  parameter int W = 2
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] stableOut
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } sync_t;

  sync_t st_ff;
  sync_t nxt_st;

  // The first stage feeds only the second; a bit changes once stages two and three agree.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = pinIn;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.stable = (st_ff.s2 & st_ff.s3) | (st_ff.stable & (st_ff.s2 ^ st_ff.s3));
    if (!rst_n)
    begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    st_ff <= nxt_st;
  end

  assign stableOut = st_ff.stable;

endmodule

// File: core/i2c_target_config_gate.sv
// Behaviour
// - Read-data window read launches internal read at read-address window when read permitted.
// - Write-data window write launches internal write at write-address window when permitted.
// - Respond enable clear blocks every remote internal access despite read/write permits.
// - With alert permit set, answer alert response address 0001100 reads when status pending.
// - Alert response only while pending alert flag set; never with alert permit clear.
// - Alert reply returns own seven-bit address then 0, then clears alert flag.
// - Alert permit clear: alert address may serve as an ordinary own address.
// - Alert permit set and own address equal alert address: alert behaviour wins.
// - Respond enable set: acknowledge addresses matching own target address.
// - Respond enable clear: not-acknowledge everything except permitted alert response reads.
// - Own target address is seven low bits of config word, reset 0x30.
// - Two low address bits latched from pins; writable only with unlock set same write.
// - General-call transactions are ignored and not-acknowledged.
`timescale 1ns/1ps

module i2c_target_config_gate
  import tcg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [tcg_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [tcg_pkg::DATA_W-1:0] wdata,
  input wire logic [tcg_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [tcg_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [tcg_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  input wire logic [tcg_pkg::LOCK_W-1:0] addrStrap,
  input wire logic addrStrobe,
  input wire logic [tcg_pkg::BYTE_W-1:0] addrByte,
  output logic addrAck,
  output logic alertMode,
  output logic [tcg_pkg::BYTE_W-1:0] alertReplyByte,
  input wire logic alertDone,
  input wire logic alertFlag,
  output logic alertClear,
  input wire logic rdWinStrobe,
  input wire logic [tcg_pkg::DATA_W-1:0] rdWinAddr,
  output logic intRdReq,
  output logic [tcg_pkg::DATA_W-1:0] intRdAddr,
  input wire logic wrWinStrobe,
  input wire logic [tcg_pkg::DATA_W-1:0] wrWinAddr,
  input wire logic [tcg_pkg::DATA_W-1:0] wrWinData,
  output logic intWrReq,
  output logic [tcg_pkg::DATA_W-1:0] intWrAddr,
  output logic [tcg_pkg::DATA_W-1:0] intWrData
);

  import tcg_pkg::*;

  typedef struct packed {
    strap_state_t strapState;
    logic [SETTLE_W-1:0] settleCnt;
    logic rdPermit;
    logic wrPermit;
    logic alertPermit;
    logic respond;
    logic unlock;
    logic [OWN_ADDR_W-1:0] ownAddr;
    logic awTaken;
    logic [ADDR_W-1:0] awAddr;
    logic wTaken;
    logic [DATA_W-1:0] wData;
    logic [STRB_W-1:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic addrAck;
    logic alertMode;
    logic [BYTE_W-1:0] alertReply;
    logic alertClear;
    logic intRdReq;
    logic [DATA_W-1:0] intRdAddr;
    logic intWrReq;
    logic [DATA_W-1:0] intWrAddr;
    logic [DATA_W-1:0] intWrData;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic [LOCK_W-1:0] strapLevel;
  logic [DATA_W-1:0] cfgWord;
  logic [DATA_W-1:0] cfgNew;
  logic [DATA_W-1:0] maskNew;
  logic [OWN_ADDR_W-1:0] rxAddr;
  logic rxRead;
  logic alertClaim;
  logic alertHit;
  logic ownHit;
  logic rdGo;
  logic wrGo;
  logic cfgWrOpen;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;

  //////////////////////////////////////////////////////////////////////////////

  strap_sync #(
    .W(LOCK_W)
  ) strap_sync_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinIn(addrStrap),
    .stableOut(strapLevel)
  );

  function automatic logic [DATA_W-1:0] mergeBytes(
    input logic [DATA_W-1:0] oldWord,
    input logic [DATA_W-1:0] newWord,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] res;
    res = oldWord;
    for (int i = 0; i < STRB_W; i++)
    begin
      if (strb[i])
      begin
        res[i*BYTE_W +: BYTE_W] = newWord[i*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction

  function automatic logic isReg(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offset
  );
    return addr[ADDR_W-1:WORD_LSB] == offset[ADDR_W-1:WORD_LSB];
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    nxt_st = st_ff;
    ev = '0;
    clr = '0;
    cfgWord = ZERO_WORD;
    cfgWord[BIT_RD_PERMIT] = st_ff.rdPermit;
    cfgWord[BIT_WR_PERMIT] = st_ff.wrPermit;
    cfgWord[BIT_ALERT_PERMIT] = st_ff.alertPermit;
    cfgWord[BIT_RESPOND] = st_ff.respond;
    cfgWord[BIT_UNLOCK] = st_ff.unlock;
    cfgWord[ADDR_MSB:0] = st_ff.ownAddr;
    cfgNew = mergeBytes(cfgWord, st_ff.wData, st_ff.wStrb);
    maskNew = mergeBytes({{(DATA_W-EV_W){1'b0}}, st_ff.mask}, st_ff.wData, st_ff.wStrb);
    cfgWrOpen = st_ff.awTaken && st_ff.wTaken && isReg(st_ff.awAddr, CFG_OFFSET)
      && cfgNew[BIT_UNLOCK];

    // Pulses last one cycle.
    nxt_st.addrAck = 1'b0;
    nxt_st.alertClear = 1'b0;
    nxt_st.intRdReq = 1'b0;
    nxt_st.intWrReq = 1'b0;

    // The strap is caught once, after the synchroniser has had time to fill.
    unique case (st_ff.strapState)
      ST_SETTLE:
      begin
        nxt_st.settleCnt = st_ff.settleCnt + SETTLE_STEP;
        if (st_ff.settleCnt == STRAP_SETTLE)
        begin
          nxt_st.ownAddr[LOCK_W-1:0] = strapLevel;
          nxt_st.strapState = ST_RUN;
        end
      end
      ST_RUN:
      begin
        nxt_st.strapState = ST_RUN;
      end
    endcase

    // Address byte decision, taken on the ninth clock of the address byte.
    rxAddr = addrByte[BYTE_W-1:1];
    rxRead = addrByte[0];
    alertClaim = st_ff.alertPermit && (rxAddr == ALERT_RESP_ADDR);
    alertHit = alertClaim && rxRead && alertFlag;
    ownHit = st_ff.respond && (rxAddr == st_ff.ownAddr)
      && (rxAddr != GENERAL_CALL_ADDR) && !alertClaim;
    if (addrStrobe)
    begin
      nxt_st.addrAck = alertHit || ownHit;
      nxt_st.alertMode = alertHit;
      if (alertHit)
      begin
        nxt_st.alertReply = {st_ff.ownAddr, 1'b0};
      end
    end
    else if (alertDone && st_ff.alertMode)
    begin
      nxt_st.alertMode = 1'b0;
      nxt_st.alertClear = 1'b1;
      ev[EV_ALERT] = 1'b1;
    end

    // Remote window accesses reach the core only when both gates are open.
    rdGo = st_ff.respond && st_ff.rdPermit;
    wrGo = st_ff.respond && st_ff.wrPermit;
    if (rdWinStrobe)
    begin
      if (rdGo)
      begin
        nxt_st.intRdReq = 1'b1;
        nxt_st.intRdAddr = rdWinAddr;
        ev[EV_RD_DONE] = 1'b1;
      end
      else
      begin
        ev[EV_DENIED] = 1'b1;
      end
    end
    if (wrWinStrobe)
    begin
      if (wrGo)
      begin
        nxt_st.intWrReq = 1'b1;
        nxt_st.intWrAddr = wrWinAddr;
        nxt_st.intWrData = wrWinData;
        ev[EV_WR_DONE] = 1'b1;
      end
      else
      begin
        ev[EV_DENIED] = 1'b1;
      end
    end

    // Register bus: write address and data are caught separately, then applied together.
    if (awvalid && awready)
    begin
      nxt_st.awTaken = 1'b1;
      nxt_st.awAddr = awaddr;
    end
    if (wvalid && wready)
    begin
      nxt_st.wTaken = 1'b1;
      nxt_st.wData = wdata;
      nxt_st.wStrb = wstrb;
    end
    if (st_ff.awTaken && st_ff.wTaken)
    begin
      nxt_st.awTaken = 1'b0;
      nxt_st.wTaken = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      if (isReg(st_ff.awAddr, CFG_OFFSET))
      begin
        nxt_st.rdPermit = cfgNew[BIT_RD_PERMIT];
        nxt_st.wrPermit = cfgNew[BIT_WR_PERMIT];
        nxt_st.alertPermit = cfgNew[BIT_ALERT_PERMIT];
        nxt_st.respond = cfgNew[BIT_RESPOND];
        nxt_st.unlock = cfgNew[BIT_UNLOCK];
        nxt_st.ownAddr[ADDR_MSB:LOCK_W] = cfgNew[ADDR_MSB:LOCK_W];
        if (cfgNew[BIT_UNLOCK])
        begin
          nxt_st.ownAddr[LOCK_W-1:0] = cfgNew[LOCK_W-1:0];
        end
      end
      else if (isReg(st_ff.awAddr, IRQ_MASK_OFFSET))
      begin
        nxt_st.mask = maskNew[EV_W-1:0];
      end
      else if (!isReg(st_ff.awAddr, IRQ_STATUS_OFFSET))
      begin
        nxt_st.bresp = RESP_SLVERR;
      end
    end
    if (st_ff.bvalid && bready)
    begin
      nxt_st.bvalid = 1'b0;
    end

    if (arvalid && arready)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      nxt_st.rdata = ZERO_WORD;
      if (isReg(araddr, CFG_OFFSET))
      begin
        nxt_st.rdata = cfgWord;
      end
      else if (isReg(araddr, IRQ_MASK_OFFSET))
      begin
        nxt_st.rdata[EV_W-1:0] = st_ff.mask;
      end
      else if (isReg(araddr, IRQ_STATUS_OFFSET))
      begin
        nxt_st.rdata[EV_W-1:0] = st_ff.status;
        clr = st_ff.status;
      end
      else
      begin
        nxt_st.rresp = RESP_SLVERR;
      end
    end
    else if (st_ff.rvalid && rready)
    begin
      nxt_st.rvalid = 1'b0;
    end

    // An event in the cycle of the clearing read survives it.
    nxt_st.status = (st_ff.status & ~clr) | ev;

    if (!rst_n)
    begin
      nxt_st = '0;
      nxt_st.strapState = ST_SETTLE;
      nxt_st.rdPermit = CFG_RESET[BIT_RD_PERMIT];
      nxt_st.wrPermit = CFG_RESET[BIT_WR_PERMIT];
      nxt_st.alertPermit = CFG_RESET[BIT_ALERT_PERMIT];
      nxt_st.respond = CFG_RESET[BIT_RESPOND];
      nxt_st.unlock = CFG_RESET[BIT_UNLOCK];
      nxt_st.ownAddr = CFG_RESET[ADDR_MSB:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    st_ff <= nxt_st;
  end

  //////////////////////////////////////////////////////////////////////////////

  // One write and one read in flight keep the slave free of any queue.
  assign awready = !st_ff.awTaken && !st_ff.bvalid;
  assign wready = !st_ff.wTaken && !st_ff.bvalid;
  assign arready = !st_ff.rvalid;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign rvalid = st_ff.rvalid;
  assign rdata = st_ff.rdata;
  assign rresp = st_ff.rresp;
  assign irq = |(st_ff.status & st_ff.mask);
  assign addrAck = st_ff.addrAck;
  assign alertMode = st_ff.alertMode;
  assign alertReplyByte = st_ff.alertReply;
  assign alertClear = st_ff.alertClear;
  assign intRdReq = st_ff.intRdReq;
  assign intRdAddr = st_ff.intRdAddr;
  assign intWrReq = st_ff.intWrReq;
  assign intWrAddr = st_ff.intWrAddr;
  assign intWrData = st_ff.intWrData;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (!rst_n);

  a_rd_launch: assert property (
    rdWinStrobe && st_ff.respond && st_ff.rdPermit
    |=> intRdReq && intRdAddr == $past(rdWinAddr))
    else $error("Permitted window read did not launch an internal read.");

  a_wr_launch: assert property (
    wrWinStrobe && st_ff.respond && st_ff.wrPermit
    |=> intWrReq && intWrAddr == $past(wrWinAddr) && intWrData == $past(wrWinData))
    else $error("Permitted window write did not launch an internal write.");

  a_access_blocked: assert property (
    !st_ff.respond |=> !intRdReq && !intWrReq)
    else $error("Internal access launched while the target was disabled.");

  a_alert_reply: assert property (
    addrStrobe && st_ff.alertPermit && addrByte[BYTE_W-1:1] == ALERT_RESP_ADDR
    && addrByte[0] && alertFlag
    |=> addrAck && alertMode && alertReplyByte == {$past(st_ff.ownAddr), 1'b0})
    else $error("Alert response read was not answered with the own address.");

  a_alert_quiet: assert property (
    addrStrobe && !(st_ff.alertPermit && alertFlag) |=> !alertMode)
    else $error("Alert response given without permit or pending flag.");

  a_alert_clear: assert property (
    alertMode && alertDone && !addrStrobe |=> alertClear && !alertMode ##1 !alertClear)
    else $error("Pending alert flag was not cleared once after the reply.");

  a_alert_wins: assert property (
    addrStrobe && st_ff.alertPermit && addrByte[BYTE_W-1:1] == ALERT_RESP_ADDR && !alertFlag
    |=> !addrAck)
    else $error("Alert address acknowledged as an ordinary target access.");

  a_own_ack: assert property (
    addrStrobe && st_ff.respond && addrByte[BYTE_W-1:1] == st_ff.ownAddr
    && st_ff.ownAddr != GENERAL_CALL_ADDR
    && !(st_ff.alertPermit && st_ff.ownAddr == ALERT_RESP_ADDR)
    |=> addrAck ##1 (!addrAck || $past(addrStrobe)))
    else $error("Own target address was not acknowledged for exactly one cycle.");

  a_nack_off: assert property (
    addrStrobe && !st_ff.respond && !(st_ff.alertPermit && alertFlag) |=> !addrAck)
    else $error("Transaction acknowledged while the target was disabled.");

  a_gen_call: assert property (
    addrStrobe && addrByte[BYTE_W-1:1] == GENERAL_CALL_ADDR |=> !addrAck)
    else $error("General call was acknowledged.");

  a_low_locked: assert property (
    st_ff.strapState == ST_RUN && !cfgWrOpen |=> $stable(st_ff.ownAddr[LOCK_W-1:0]))
    else $error("Locked low address bits changed.");

  a_cfg_reset: assert property (
    $rose(rst_n) |-> cfgWord == CFG_RESET)
    else $error("Configuration word does not hold its reset value.");

endmodule

// File: verif/wire_master_model.sv
`timescale 1ns/1ps

module wire_master_model (
  input wire logic mclk,
  output logic addrStrobe,
  output logic [tcg_pkg::BYTE_W-1:0] addrByte,
  output logic alertDone,
  output logic alertFlag,
  input wire logic alertClear,
  output logic rdWinStrobe,
  output logic [tcg_pkg::DATA_W-1:0] rdWinAddr,
  output logic wrWinStrobe,
  output logic [tcg_pkg::DATA_W-1:0] wrWinAddr,
  output logic [tcg_pkg::DATA_W-1:0] wrWinData
);
  import tcg_pkg::*;

  initial
  begin
    addrStrobe = 1'b0;
    addrByte = 8'hFF;
    alertDone = 1'b0;
    alertFlag = 1'b0;
    rdWinStrobe = 1'b0;
    rdWinAddr = 32'h0000_0000;
    wrWinStrobe = 1'b0;
    wrWinData = 32'h0000_0000;
    wrWinAddr = 32'h0000_0000;
  end

  //////////////////////////////////////////////////////////////////////////////

  // The pending flag drops only when the device asks for it.
  always @(posedge mclk)
    if (alertClear)
      alertFlag <= 1'b0;

  task automatic raiseFlag();
    @(posedge mclk);
    alertFlag <= 1'b1;
  endtask

  // A released byte shows its inverse so that a stale value never matches by luck.
  task automatic sendAddr(input logic [OWN_ADDR_W-1:0] a, input logic rw);
    @(posedge mclk);
    addrStrobe <= 1'b1;
    addrByte <= {a, rw};
    @(posedge mclk);
    addrStrobe <= 1'b0;
    addrByte <= ~{a, rw};
  endtask

  task automatic winAccess(input logic rd, input logic wr, input logic [DATA_W-1:0] ra,
                           input logic [DATA_W-1:0] wa, input logic [DATA_W-1:0] wd);
    @(posedge mclk);
    rdWinStrobe <= rd;
    wrWinStrobe <= wr;
    rdWinAddr <= ra;
    wrWinAddr <= wa;
    wrWinData <= wd;
    @(posedge mclk);
    rdWinStrobe <= 1'b0;
    wrWinStrobe <= 1'b0;
    rdWinAddr <= ~ra;
    wrWinAddr <= ~wa;
    wrWinData <= ~wd;
  endtask

  task automatic replyDone();
    @(posedge mclk);
    alertDone <= 1'b1;
    @(posedge mclk);
    alertDone <= 1'b0;
  endtask
endmodule

// File: verif/i2c_target_config_gate_test.sv
`timescale 1ns/1ps

module i2c_target_config_gate_test;
  import tcg_pkg::*;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [DATA_W-1:0] wdata = '0;
  logic [STRB_W-1:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [DATA_W-1:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic irq, addrStrobe, addrAck, alertMode, alertDone, alertFlag, alertClear;
  logic [BYTE_W-1:0] addrByte, alertReplyByte;
  logic rdWinStrobe, wrWinStrobe, intRdReq, intWrReq;
  logic [DATA_W-1:0] rdWinAddr, intRdAddr, wrWinAddr, wrWinData, intWrAddr, intWrData;
  logic [LOCK_W-1:0] addrStrap = 2'h1;
  int errorCnt = 0;
  int nCompared = 0;
  logic [1:0] lastBresp = 2'h0;

  i2c_target_config_gate i2c_target_config_gate_i (.mclk(mclk), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq(irq), .addrStrap(addrStrap),
    .addrStrobe(addrStrobe), .addrByte(addrByte), .addrAck(addrAck), .alertMode(alertMode),
    .alertReplyByte(alertReplyByte), .alertDone(alertDone), .alertFlag(alertFlag),
    .alertClear(alertClear), .rdWinStrobe(rdWinStrobe), .rdWinAddr(rdWinAddr),
    .intRdReq(intRdReq), .intRdAddr(intRdAddr), .wrWinStrobe(wrWinStrobe),
    .wrWinAddr(wrWinAddr), .wrWinData(wrWinData), .intWrReq(intWrReq),
    .intWrAddr(intWrAddr), .intWrData(intWrData));

  wire_master_model wire_master_model_i (.mclk(mclk), .addrStrobe(addrStrobe),
    .addrByte(addrByte), .alertDone(alertDone), .alertFlag(alertFlag),
    .alertClear(alertClear), .rdWinStrobe(rdWinStrobe), .rdWinAddr(rdWinAddr),
    .wrWinStrobe(wrWinStrobe), .wrWinAddr(wrWinAddr), .wrWinData(wrWinData));

  initial
  begin
    forever #2.5 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////////////

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic checkBit(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask

  task automatic timeOut();
    errorCnt++;
    $display("[FAIL] %0t: bus answer never came", $time);
    conclude();
  endtask

  // Handshakes are sampled at the falling edge, where nothing driven at the rising edge moves.
  task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    logic awHs;
    logic wHs;
    logic bHs;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(negedge mclk);
      awHs = awvalid && awready;
      wHs = wvalid && wready;
      bHs = bvalid;
      lastBresp = bresp;
      @(posedge mclk);
      if (awHs)
        awvalid <= 1'b0;
      if (wHs)
        wvalid <= 1'b0;
      if (bHs)
      begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50)
      timeOut();
  endtask

  task automatic readCheck(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                           input logic [1:0] expResp);
    int n;
    logic arHs;
    logic rHs;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(negedge mclk);
      arHs = arvalid && arready;
      rHs = rvalid;
      if (rHs)
      begin
        check(rdata, exp);
        check({30'h0, rresp}, {30'h0, expResp});
      end
      @(posedge mclk);
      if (arHs)
        arvalid <= 1'b0;
      if (rHs)
      begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50)
      timeOut();
  endtask

  task automatic addrCheck(input logic [OWN_ADDR_W-1:0] a, input logic rw, input logic ack,
                           input logic mode);
    wire_master_model_i.sendAddr(a, rw);
    #1;
    checkBit(addrAck, ack);
    checkBit(alertMode, mode);
  endtask

  //////////////////////////////////////////////////////////////////////////////

  task automatic testRegs();
    readCheck(CFG_OFFSET, 32'hD000_0031, RESP_OKAY);
    readCheck(IRQ_MASK_OFFSET, ZERO_WORD, RESP_OKAY);
    readCheck(20'h1D300, ZERO_WORD, RESP_SLVERR);
    axiWrite(20'h1D300, 32'hFFFF_FFFF);
    check({30'h0, lastBresp}, {30'h0, RESP_SLVERR});
    axiWrite(CFG_OFFSET, 32'hD000_0022);
    check({30'h0, lastBresp}, {30'h0, RESP_OKAY});
    readCheck(CFG_OFFSET, 32'hD000_0021, RESP_OKAY);
    axiWrite(CFG_OFFSET, 32'hD100_0022);
    readCheck(CFG_OFFSET, 32'hD100_0022, RESP_OKAY);
  endtask

  task automatic testAddr();
    addrCheck(7'h22, 1'b0, 1'b1, 1'b0);
    addrCheck(7'h23, 1'b1, 1'b0, 1'b0);
    addrCheck(GENERAL_CALL_ADDR, 1'b0, 1'b0, 1'b0);
    axiWrite(CFG_OFFSET, 32'hC100_0022);
    addrCheck(7'h22, 1'b1, 1'b0, 1'b0);
  endtask

  task automatic testWindows();
    logic [DATA_W-1:0] cfgs [4];
    logic expRd;
    logic expWr;
    cfgs = '{32'hD100_0022, 32'h5100_0022, 32'h9100_0022, 32'hC100_0022};
    axiWrite(IRQ_MASK_OFFSET, 32'h0000_000F);
    for (int i = 0; i < 4; i++)
    begin
      expRd = cfgs[i][BIT_RESPOND] && cfgs[i][BIT_RD_PERMIT];
      expWr = cfgs[i][BIT_RESPOND] && cfgs[i][BIT_WR_PERMIT];
      axiWrite(CFG_OFFSET, cfgs[i]);
      wire_master_model_i.winAccess(1'b1, 1'b1, 32'h100 + i, 32'h200 + i, 32'hA5A5_0000 + i);
      #1;
      checkBit(intRdReq, expRd);
      checkBit(intWrReq, expWr);
      if (expRd)
        check(intRdAddr, 32'h100 + i);
      if (expWr)
      begin
        check(intWrAddr, 32'h200 + i);
        check(intWrData, 32'hA5A5_0000 + i);
      end
    end
    checkBit(irq, 1'b1);
    readCheck(IRQ_STATUS_OFFSET, 32'h0000_000B, RESP_OKAY);
    @(posedge mclk);
    #1;
    checkBit(irq, 1'b0);
  endtask

  // Software never programs an own address of zero anywhere in this run.
  task automatic testAlert();
    axiWrite(CFG_OFFSET, 32'h2100_0022);
    wire_master_model_i.raiseFlag();
    addrCheck(ALERT_RESP_ADDR, 1'b1, 1'b1, 1'b1);
    check({24'h0, alertReplyByte}, 32'h0000_0044);
    wire_master_model_i.replyDone();
    #1;
    checkBit(alertClear, 1'b1);
    checkBit(alertMode, 1'b0);
    readCheck(IRQ_STATUS_OFFSET, 32'h0000_0004, RESP_OKAY);
    addrCheck(ALERT_RESP_ADDR, 1'b1, 1'b0, 1'b0);
    wire_master_model_i.raiseFlag();
    addrCheck(ALERT_RESP_ADDR, 1'b0, 1'b0, 1'b0);
    axiWrite(CFG_OFFSET, 32'h3100_000C);
    addrCheck(ALERT_RESP_ADDR, 1'b1, 1'b1, 1'b1);
    check({24'h0, alertReplyByte}, 32'h0000_0018);
    addrCheck(ALERT_RESP_ADDR, 1'b0, 1'b0, 1'b0);
    axiWrite(CFG_OFFSET, 32'h1100_000C);
    addrCheck(ALERT_RESP_ADDR, 1'b0, 1'b1, 1'b0);
    axiWrite(CFG_OFFSET, 32'h0100_000C);
    addrCheck(ALERT_RESP_ADDR, 1'b1, 1'b0, 1'b0);
  endtask

  //////////////////////////////////////////////////////////////////////////////

  // The strap is sampled some cycles after release, so the bench waits before the first read.
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (12) @(posedge mclk);
    testRegs();
    testAddr();
    testWindows();
    testAlert();
    conclude();
  end
endmodule
